// [rtl/css_route.sv]
// per-signal routing of terminal and communication commands
`timescale 1ns/1ps
`default_nettype none
`include "css_regs.svh"
module css_route (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// routing carrier
	css_route_if.route rt
);
	genvar i;
	generate
		for (i = 0; i < `CSS_NSIG; i++) begin : g_sig
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					rt.eff_cmd[i] <= 1'b0;
				end else begin
					rt.eff_cmd[i] <= (rt.take_term[i] & rt.term_cmd[i]) |
						(rt.take_comm[i] & rt.comm_cmd[i]);
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// [rtl/css_sync.sv]
// two-stage synchroniser for the control terminal pins
`timescale 1ns/1ps
`default_nettype none
module css_sync #(
	parameter int W = 5
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pins and synchronised levels
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] meta;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			level <= '0;
		end else begin
			meta <= pin;
			level <= meta;
		end
	end
endmodule
`default_nettype wire

// [rtl/css_top.sv]
// command source selector with apb register file
`timescale 1ns/1ps
`default_nettype none
`include "css_regs.svh"

// Notes on behaviour
// - separate start/function source and speed source are kept in network mode.
// - source-switch input exists only when a terminal is assigned code 67.
// - source-switch off forces all commands from terminals, communication ignored.
// - switch unassigned or on: sources follow operation and speed settings.
// - source-switch changes are applied only while the drive is stopped.
// - communication reset is rejected while the source-switch input is off.
// - source settings may be written while running when write setting is 2.
// - newly written source settings take effect only once the drive stops.
// - terminal-only signals use the terminal and ignore communication.
// - network-only signals use communication and ignore the terminal.
// - combined signals accept either terminal or communication.
// - run enable always comes from the terminals.
// - pu external interlock always comes from the terminals.
// - pid enable from communication at speed source 0, else terminals.
// - pid direction switch from communication at speed source 0, else terminals.
// - pid integral reset from communication at speed source 0, else terminals.
// - mode 7 without interlock terminal makes output stop a terminal interlock.
// - communication commands come only from the selected port.
module css_top
	import css_pkg::*;
(
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// control terminal pins
	input wire logic [`CSS_NTERM-1:0] term_pin,
	// drive state
	input wire logic network_mode,
	input wire logic drive_stopped,
	// effective commands
	output logic [`CSS_NSIG-1:0] cmd_eff,
	output logic comm_reset,
	output logic speed_comm_en,
	output logic term2_en,
	output logic term4_en
);
	// =====================================================
	// declarations
	logic op_src;
	logic [1:0] spd_src;
	logic [1:0] wwr;
	logic [2:0] opmode;
	logic port_sel;
	logic [6:0] term_fn [`CSS_NTERM];
	logic [`CSS_NSIG-1:0] cmd_port0;
	logic [`CSS_NSIG-1:0] cmd_port1;
	logic reject_flag;
	logic op_eff;
	logic [1:0] spd_eff;
	logic force_term;
	logic [`CSS_NTERM-1:0] term_lvl;
	logic [`CSS_NSIG-1:0] term_cmd;
	logic [`CSS_NSIG-1:0] fn_assigned;
	logic [`CSS_NSIG-1:0] take_term;
	logic [`CSS_NSIG-1:0] take_comm;
	logic wr_en;
	logic rd_setup;
	logic addr_ok;
	logic src_wr_ok;
	logic reset_wr;
	logic next_force;
	logic [31:0] next_rdata;
	css_route_if rif();

	// =====================================================
	// terminal function lookup
	function automatic logic [6:0] css_code(input int i);
		case (i)
			`CSS_IX_LOWSPD: css_code = `CSS_FC_LOWSPD;
			`CSS_IX_MIDSPD: css_code = `CSS_FC_MIDSPD;
			`CSS_IX_HIGHSPD: css_code = `CSS_FC_HIGHSPD;
			`CSS_IX_SECFN: css_code = `CSS_FC_SECFN;
			`CSS_IX_T4SEL: css_code = `CSS_FC_T4SEL;
			`CSS_IX_JOG: css_code = `CSS_FC_JOG;
			`CSS_IX_THERM: css_code = `CSS_FC_THERM;
			`CSS_IX_SPD15: css_code = `CSS_FC_SPD15;
			`CSS_IX_RUNEN: css_code = `CSS_FC_RUNEN;
			`CSS_IX_PUILK: css_code = `CSS_FC_PUILK;
			`CSS_IX_PIDEN: css_code = `CSS_FC_PIDEN;
			`CSS_IX_PUEXT: css_code = `CSS_FC_PUEXT;
			`CSS_IX_PREEXC: css_code = `CSS_FC_PREEXC;
			`CSS_IX_OUTSTOP: css_code = `CSS_FC_OUTSTOP;
			`CSS_IX_SELFHOLD: css_code = `CSS_FC_SELFHOLD;
			`CSS_IX_FWD: css_code = `CSS_FC_FWD;
			`CSS_IX_REV: css_code = `CSS_FC_REV;
			`CSS_IX_RESET: css_code = `CSS_FC_RESET;
			`CSS_IX_PIDDIR: css_code = `CSS_FC_PIDDIR;
			`CSS_IX_PUNET: css_code = `CSS_FC_PUNET;
			`CSS_IX_EXTNET: css_code = `CSS_FC_EXTNET;
			`CSS_IX_SRCSW: css_code = `CSS_FC_SRCSW;
			default: css_code = `CSS_FC_PIDRST;
		endcase
	endfunction

	// source class of one signal for given operation and speed sources
	function automatic css_class_e css_class(input int i, input logic op,
		input logic [1:0] spd, input logic out_ilk);
		case (i)
			`CSS_IX_LOWSPD, `CSS_IX_MIDSPD, `CSS_IX_HIGHSPD, `CSS_IX_SPD15,
			`CSS_IX_PIDEN, `CSS_IX_PIDDIR, `CSS_IX_PIDRST: begin
				css_class = (spd == 2'h0) ? CSS_NETWORK : CSS_TERM;
			end
			`CSS_IX_SECFN, `CSS_IX_PREEXC, `CSS_IX_FWD, `CSS_IX_REV: begin
				css_class = op ? CSS_TERM : CSS_NETWORK;
			end
			`CSS_IX_T4SEL: begin
				css_class = (spd == 2'h0) ? CSS_NONE : CSS_BOTH;
			end
			`CSS_IX_JOG, `CSS_IX_SELFHOLD: begin
				css_class = op ? CSS_TERM : CSS_NONE;
			end
			`CSS_IX_OUTSTOP: begin
				if (out_ilk) begin
					css_class = CSS_TERM;
				end else begin
					css_class = op ? CSS_TERM : CSS_BOTH;
				end
			end
			default: css_class = CSS_TERM;
		endcase
	endfunction

	// =====================================================
	// terminal inputs
	css_sync #(
		.W(`CSS_NTERM)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(term_pin),
		.level(term_lvl)
	);

	genvar s;
	generate
		for (s = 0; s < `CSS_NSIG; s++) begin : g_fn
			always_comb begin
				term_cmd[s] = 1'b0;
				fn_assigned[s] = 1'b0;
				for (int t = 0; t < `CSS_NTERM; t++) begin
					if (term_fn[t] == css_code(s)) begin
						term_cmd[s] = term_cmd[s] | term_lvl[t];
						fn_assigned[s] = 1'b1;
					end
				end
			end
		end
	endgenerate

	// =====================================================
	// effective selection, frozen while running
	assign next_force = !network_mode ||
		(fn_assigned[`CSS_IX_SRCSW] && !term_cmd[`CSS_IX_SRCSW]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_eff <= `CSS_RST_OP_SRC;
			spd_eff <= `CSS_RST_SPD_SRC;
			force_term <= 1'b1;
		end else if (drive_stopped) begin
			op_eff <= op_src;
			spd_eff <= spd_src;
			force_term <= next_force;
		end
	end

	generate
		for (s = 0; s < `CSS_NSIG; s++) begin : g_cls
			css_class_e cls;
			always_comb begin
				if (force_term) begin
					cls = css_class(s, 1'b1, 2'h1, 1'b0);
				end else begin
					cls = css_class(s, op_eff, spd_eff,
						opmode == `CSS_OPMODE_PU_ILK &&
						!fn_assigned[`CSS_IX_PUILK]);
				end
				take_term[s] = cls[0] | force_term;
				take_comm[s] = cls[1] & !force_term;
			end
		end
	endgenerate

	assign speed_comm_en = !force_term && (spd_eff != 2'h1);
	assign term2_en = force_term || (spd_eff == 2'h1);
	assign term4_en = force_term || (spd_eff != 2'h0);

	// =====================================================
	// command routing
	assign rif.term_cmd = term_cmd;
	assign rif.comm_cmd = port_sel ? cmd_port1 : cmd_port0;
	assign rif.take_term = take_term;
	assign rif.take_comm = take_comm;
	assign cmd_eff = rif.eff_cmd;

	css_route u_route (
		.pclk(pclk),
		.presetn(presetn),
		.rt(rif)
	);

	// =====================================================
	// apb decode
	always_comb begin
		addr_ok = 1'b0;
		case (paddr)
			`CSS_OFS_OP_SRC, `CSS_OFS_SPD_SRC, `CSS_OFS_WWR, `CSS_OFS_OPMODE,
			`CSS_OFS_PORT_SEL, `CSS_OFS_CMD0, `CSS_OFS_CMD1,
			`CSS_OFS_RESET_REQ, `CSS_OFS_STATUS, `CSS_OFS_EFFECT: begin
				addr_ok = 1'b1;
			end
			default: begin
				for (int t = 0; t < `CSS_NTERM; t++) begin
					if (paddr == `CSS_OFS_TERM_FN0 + 8'(4 * t)) begin
						addr_ok = 1'b1;
					end
				end
			end
		endcase
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign wr_en = psel && penable && pwrite && addr_ok;
	assign rd_setup = psel && !penable && !pwrite;
	assign src_wr_ok = drive_stopped || (wwr == `CSS_WWR_ANYTIME);
	assign reset_wr = wr_en && paddr == `CSS_OFS_RESET_REQ && pwdata[0];

	// =====================================================
	// settings registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_src <= `CSS_RST_OP_SRC;
			spd_src <= `CSS_RST_SPD_SRC;
		end else if (wr_en && src_wr_ok) begin
			if (paddr == `CSS_OFS_OP_SRC) begin
				op_src <= pwdata[0];
			end
			if (paddr == `CSS_OFS_SPD_SRC) begin
				spd_src <= pwdata[1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wwr <= `CSS_RST_WWR;
			opmode <= `CSS_RST_OPMODE;
			port_sel <= `CSS_RST_PORT_SEL;
		end else if (wr_en) begin
			case (paddr)
				`CSS_OFS_WWR: wwr <= pwdata[1:0];
				`CSS_OFS_OPMODE: opmode <= pwdata[2:0];
				`CSS_OFS_PORT_SEL: port_sel <= pwdata[0];
				default: ;
			endcase
		end
	end

	generate
		for (s = 0; s < `CSS_NTERM; s++) begin : g_tfn
			localparam logic [7:0] OFS = `CSS_OFS_TERM_FN0 + 8'(4 * s);
			localparam logic [7*`CSS_NTERM-1:0] RST = `CSS_RST_TERM_FN;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					term_fn[s] <= RST[7*s +: 7];
				end else if (wr_en && paddr == OFS) begin
					term_fn[s] <= pwdata[6:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_port0 <= '0;
			cmd_port1 <= '0;
		end else if (wr_en) begin
			if (paddr == `CSS_OFS_CMD0) begin
				cmd_port0 <= pwdata[`CSS_NSIG-1:0];
			end
			if (paddr == `CSS_OFS_CMD1) begin
				cmd_port1 <= pwdata[`CSS_NSIG-1:0];
			end
		end
	end

	// =====================================================
	// communication reset and rejection flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comm_reset <= 1'b0;
		end else begin
			comm_reset <= reset_wr && !force_term;
		end
	end

	// a rejection in the clearing cycle keeps the flag set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reject_flag <= 1'b0;
		end else if (reset_wr && force_term) begin
			reject_flag <= 1'b1;
		end else if (wr_en && paddr == `CSS_OFS_STATUS && pwdata[0]) begin
			reject_flag <= 1'b0;
		end
	end

	// =====================================================
	// read data, captured in the setup cycle
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (paddr)
			`CSS_OFS_OP_SRC: next_rdata[0] = op_src;
			`CSS_OFS_SPD_SRC: next_rdata[1:0] = spd_src;
			`CSS_OFS_WWR: next_rdata[1:0] = wwr;
			`CSS_OFS_OPMODE: next_rdata[2:0] = opmode;
			`CSS_OFS_PORT_SEL: next_rdata[0] = port_sel;
			`CSS_OFS_CMD0: next_rdata[`CSS_NSIG-1:0] = cmd_port0;
			`CSS_OFS_CMD1: next_rdata[`CSS_NSIG-1:0] = cmd_port1;
			`CSS_OFS_STATUS: next_rdata[6:0] = {fn_assigned[`CSS_IX_SRCSW],
				term_cmd[`CSS_IX_SRCSW], drive_stopped, force_term,
				spd_eff, op_eff};
			`CSS_OFS_EFFECT: next_rdata[`CSS_NSIG-1:0] = cmd_eff;
			default: begin
				for (int t = 0; t < `CSS_NTERM; t++) begin
					if (paddr == `CSS_OFS_TERM_FN0 + 8'(4 * t)) begin
						next_rdata[6:0] = term_fn[t];
					end
				end
			end
		endcase
		if (paddr == `CSS_OFS_STATUS) begin
			next_rdata[7] = reject_flag;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= next_rdata;
		end
	end
endmodule
`default_nettype wire

// [shared/css_pkg.sv]
// types of the command source selector
`default_nettype none
package css_pkg;
	// bit 0: terminal accepted, bit 1: communication accepted
	typedef enum logic [1:0] {
		CSS_NONE = 2'b00,
		CSS_TERM = 2'b01,
		CSS_NETWORK = 2'b10,
		CSS_BOTH = 2'b11
	} css_class_e;
endpackage
`default_nettype wire

// [shared/css_regs.svh]
// register offsets, reset values, function codes and signal indices
`ifndef CSS_REGS_SVH
`define CSS_REGS_SVH

`define CSS_NSIG 23
`define CSS_NTERM 5
// apb byte offsets
`define CSS_OFS_OP_SRC 8'h00
`define CSS_OFS_SPD_SRC 8'h04
`define CSS_OFS_WWR 8'h08
`define CSS_OFS_OPMODE 8'h0C
`define CSS_OFS_PORT_SEL 8'h10
`define CSS_OFS_TERM_FN0 8'h14
`define CSS_OFS_CMD0 8'h28
`define CSS_OFS_CMD1 8'h2C
`define CSS_OFS_RESET_REQ 8'h30
`define CSS_OFS_STATUS 8'h34
`define CSS_OFS_EFFECT 8'h38
// reset values
`define CSS_RST_OP_SRC 1'h0
`define CSS_RST_SPD_SRC 2'h0
`define CSS_RST_WWR 2'h0
`define CSS_RST_OPMODE 3'h0
`define CSS_RST_PORT_SEL 1'h0
`define CSS_RST_TERM_FN {7'h3C, 7'h3D, 7'h00, 7'h01, 7'h02}
// setting values
`define CSS_WWR_ANYTIME 2'h2
`define CSS_OPMODE_PU_ILK 3'h7
// input terminal function codes
`define CSS_FC_LOWSPD 7'h00
`define CSS_FC_MIDSPD 7'h01
`define CSS_FC_HIGHSPD 7'h02
`define CSS_FC_SECFN 7'h03
`define CSS_FC_T4SEL 7'h04
`define CSS_FC_JOG 7'h05
`define CSS_FC_THERM 7'h07
`define CSS_FC_SPD15 7'h08
`define CSS_FC_RUNEN 7'h0A
`define CSS_FC_PUILK 7'h0C
`define CSS_FC_PIDEN 7'h0E
`define CSS_FC_PUEXT 7'h10
`define CSS_FC_PREEXC 7'h17
`define CSS_FC_OUTSTOP 7'h18
`define CSS_FC_SELFHOLD 7'h19
`define CSS_FC_FWD 7'h3C
`define CSS_FC_REV 7'h3D
`define CSS_FC_RESET 7'h3E
`define CSS_FC_PIDDIR 7'h40
`define CSS_FC_PUNET 7'h41
`define CSS_FC_EXTNET 7'h42
`define CSS_FC_SRCSW 7'h43
`define CSS_FC_PIDRST 7'h48
// bit positions in command vectors
`define CSS_IX_LOWSPD 0
`define CSS_IX_MIDSPD 1
`define CSS_IX_HIGHSPD 2
`define CSS_IX_SECFN 3
`define CSS_IX_T4SEL 4
`define CSS_IX_JOG 5
`define CSS_IX_THERM 6
`define CSS_IX_SPD15 7
`define CSS_IX_RUNEN 8
`define CSS_IX_PUILK 9
`define CSS_IX_PIDEN 10
`define CSS_IX_PUEXT 11
`define CSS_IX_PREEXC 12
`define CSS_IX_OUTSTOP 13
`define CSS_IX_SELFHOLD 14
`define CSS_IX_FWD 15
`define CSS_IX_REV 16
`define CSS_IX_RESET 17
`define CSS_IX_PIDDIR 18
`define CSS_IX_PUNET 19
`define CSS_IX_EXTNET 20
`define CSS_IX_SRCSW 21
`define CSS_IX_PIDRST 22

`endif

// [shared/css_route_if.sv]
// carrier between source classification and command routing
`timescale 1ns/1ps
`default_nettype none
`include "css_regs.svh"
interface css_route_if;
	logic [`CSS_NSIG-1:0] term_cmd;
	logic [`CSS_NSIG-1:0] comm_cmd;
	logic [`CSS_NSIG-1:0] take_term;
	logic [`CSS_NSIG-1:0] take_comm;
	logic [`CSS_NSIG-1:0] eff_cmd;
	modport ctrl (output term_cmd, comm_cmd, take_term, take_comm,
		input eff_cmd);
	modport route (input term_cmd, comm_cmd, take_term, take_comm,
		output eff_cmd);
endinterface
`default_nettype wire

// [sim/css_term_model.sv]
// control terminal pins as an external switch panel drives them
`timescale 1ns/1ps
`default_nettype none
`include "css_regs.svh"
module css_term_model (
	// clock
	input wire logic pclk,
	// wanted and driven levels
	input wire logic [`CSS_NTERM-1:0] want,
	output logic [`CSS_NTERM-1:0] term_pin
);
	// contacts move just after an edge
	always @(posedge pclk) begin
		term_pin <= want;
	end
endmodule
`default_nettype wire

// [sim/css_top_properties.sv]
// port checks of the command source selector
`timescale 1ns/1ps
`default_nettype none
`include "css_regs.svh"
module css_checker (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// terminals and drive state
	input wire logic [`CSS_NTERM-1:0] term_pin,
	input wire logic network_mode,
	input wire logic drive_stopped,
	// results
	input wire logic [`CSS_NSIG-1:0] cmd_eff,
	input wire logic comm_reset,
	input wire logic speed_comm_en,
	input wire logic term2_en,
	input wire logic term4_en
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic unmapped;
	logic rst_wr;
	assign unmapped = paddr > `CSS_OFS_EFFECT || paddr[1:0] != 2'b00;
	assign rst_wr = psel && penable && pwrite && pwdata[0] &&
		paddr == `CSS_OFS_RESET_REQ;
	// ========
	// sequences and properties
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_forced;
		(!network_mode && drive_stopped)[*3];
	endsequence
	a_zero_wait: assert property (pready)
		else $error("pready low");
	a_bad_addr: assert property (s_acc ##0 unmapped |-> pslverr)
		else $error("unmapped access without error");
	a_bad_read: assert property (s_acc ##0 (unmapped && !pwrite)
		|-> prdata == 32'h0) else $error("unmapped read not zero");
	a_effect_mirror: assert property (psel && !penable && !pwrite &&
		paddr == `CSS_OFS_EFFECT |=> prdata == {9'h0, $past(cmd_eff)})
		else $error("effect read differs");
	a_pulse_single: assert property (comm_reset |=> !comm_reset)
		else $error("reset pulse too long");
	a_pulse_cause:
		assert property ($rose(comm_reset) |-> $past(rst_wr))
		else $error("reset pulse without request");
	a_reset_blocked:
		assert property (s_forced ##0 rst_wr |=> !comm_reset)
		else $error("reset accepted while forced");
	a_hold_running:
		assert property (!drive_stopped
		|=> $stable({speed_comm_en, term2_en, term4_en}))
		else $error("selection moved while running");
	a_forced_terms:
		assert property (s_forced |-> !speed_comm_en && term2_en &&
		term4_en) else $error("speed not forced to terminals");
endmodule
bind css_top css_checker u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .term_pin,
	.network_mode, .drive_stopped, .cmd_eff, .comm_reset,
	.speed_comm_en, .term2_en, .term4_en);
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the command source selector
`timescale 1ns/1ps
`default_nettype none
`include "css_regs.svh"
module tb;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [4:0] want = '0;
	logic [4:0] term_pin;
	logic network_mode = 1;
	logic drive_stopped = 1;
	logic [22:0] cmd_eff;
	logic comm_reset;
	logic speed_comm_en;
	logic term2_en;
	logic term4_en;
	logic [31:0] rdat;
	logic rerr;
	int failures = 0;
	int n_checks = 0;
	int cyc = 0;
	always #12.5 pclk = ~pclk;
	css_term_model far (.pclk, .want, .term_pin);
	css_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .term_pin, .network_mode,
		.drive_stopped, .cmd_eff, .comm_reset, .speed_comm_en,
		.term2_en, .term4_en);
	// ========
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(0, a, 32'h0);
		chk(rdat, exp);
	endtask
	task automatic effchk(input logic [31:0] exp);
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		chk({9'h0, cmd_eff}, exp);
	endtask
	task automatic done(input string s);
		$display("test %0s done", s);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			tally_and_finish;
		end
	end
	// ========
	// tests
	initial begin
		repeat (5) @(posedge pclk);
		chkb(speed_comm_en, 1'b0);
		chkb(term2_en, 1'b1);
		chkb(term4_en, 1'b1);
		presetn <= 1;
		effchk(32'h0000_0000);
		rdchk(`CSS_OFS_STATUS, 32'h0000_0010);
		rdchk(`CSS_OFS_TERM_FN0, 32'h0000_0002);
		rdchk(`CSS_OFS_TERM_FN0 + 8'h10, 32'h0000_003C);
		chkb(speed_comm_en, 1'b1);
		chkb(term2_en, 1'b0);
		chkb(term4_en, 1'b0);
		rdchk(8'h3C, 32'h0000_0000);
		chkb(rerr, 1'b1);
		done("reset");
		want <= 5'h01;
		xfer(1, `CSS_OFS_CMD0, 32'h0000_A500);
		effchk(32'h0000_A400);
		xfer(1, `CSS_OFS_TERM_FN0 + 8'h08, 32'h0000_000A);
		xfer(1, `CSS_OFS_TERM_FN0 + 8'h04, 32'h0000_000E);
		want <= 5'h07;
		xfer(1, `CSS_OFS_OP_SRC, 32'h0000_0001);
		xfer(1, `CSS_OFS_SPD_SRC, 32'h0000_0001);
		effchk(32'h0000_0504);
		chkb(speed_comm_en, 1'b0);
		chkb(term2_en, 1'b1);
		chkb(term4_en, 1'b1);
		done("routing");
		xfer(1, `CSS_OFS_OP_SRC, 32'h0000_0000);
		xfer(1, `CSS_OFS_SPD_SRC, 32'h0000_0000);
		xfer(1, `CSS_OFS_CMD0, 32'h0000_0000);
		xfer(1, `CSS_OFS_CMD1, 32'h0000_8000);
		effchk(32'h0000_0100);
		xfer(1, `CSS_OFS_PORT_SEL, 32'h0000_0001);
		effchk(32'h0000_8100);
		rdchk(`CSS_OFS_EFFECT, 32'h0000_8100);
		done("port");
		@(posedge pclk) drive_stopped <= 0;
		xfer(1, `CSS_OFS_OP_SRC, 32'h0000_0001);
		rdchk(`CSS_OFS_OP_SRC, 32'h0000_0000);
		xfer(1, `CSS_OFS_WWR, 32'h0000_0002);
		xfer(1, `CSS_OFS_OP_SRC, 32'h0000_0001);
		rdchk(`CSS_OFS_OP_SRC, 32'h0000_0001);
		effchk(32'h0000_8100);
		@(posedge pclk) drive_stopped <= 1;
		effchk(32'h0000_0100);
		done("running");
		xfer(1, `CSS_OFS_OP_SRC, 32'h0000_0000);
		xfer(1, `CSS_OFS_CMD1, 32'h0000_2000);
		effchk(32'h0000_2100);
		xfer(1, `CSS_OFS_OPMODE, 32'h0000_0007);
		effchk(32'h0000_0100);
		xfer(1, `CSS_OFS_OPMODE, 32'h0000_0000);
		xfer(1, `CSS_OFS_SPD_SRC, 32'h0000_0002);
		effchk(32'h0000_2504);
		chkb(speed_comm_en, 1'b1);
		chkb(term2_en, 1'b0);
		chkb(term4_en, 1'b1);
		xfer(1, `CSS_OFS_SPD_SRC, 32'h0000_0000);
		done("interlock");
		xfer(1, `CSS_OFS_CMD1, 32'h0000_8000);
		@(posedge pclk) network_mode <= 0;
		effchk(32'h0000_0504);
		xfer(1, `CSS_OFS_RESET_REQ, 32'h0000_0001);
		@(negedge pclk) chkb(comm_reset, 1'b0);
		@(posedge pclk) network_mode <= 1;
		xfer(1, `CSS_OFS_TERM_FN0 + 8'h0C, 32'h0000_0043);
		effchk(32'h0000_0504);
		xfer(0, `CSS_OFS_STATUS, 32'h0000_0000);
		chk(rdat & 32'h0000_00F8, 32'h0000_00D8);
		@(posedge pclk) drive_stopped <= 0;
		want <= 5'h0F;
		effchk(32'h0020_0504);
		@(posedge pclk) drive_stopped <= 1;
		effchk(32'h0020_8100);
		xfer(1, `CSS_OFS_STATUS, 32'h0000_0001);
		xfer(1, `CSS_OFS_RESET_REQ, 32'h0000_0001);
		@(negedge pclk) chkb(comm_reset, 1'b1);
		@(negedge pclk) chkb(comm_reset, 1'b0);
		xfer(0, `CSS_OFS_STATUS, 32'h0000_0000);
		chk(rdat & 32'h0000_0080, 32'h0000_0000);
		done("source switch");
		tally_and_finish;
	end
endmodule
`default_nettype wire
